// ==== inc/wcm_regs.svh ====
// Register offsets, field positions, reset values and timing counts
// Assumes a 100 MHz register clock and byte addresses on a 32-bit bus
`ifndef WCM_REGS_SVH
`define WCM_REGS_SVH

// Register byte offsets
`define WCM_CTRL_OFS     8'h00
`define WCM_STAT_OFS     8'h04
`define WCM_MASK_OFS     8'h08
`define WCM_CRCV_OFS     8'h0c

// Control fields and reset value (x8, burst of eight, all off)
`define WCM_CTRL_CRC_EN  0
`define WCM_CTRL_DM_EN   1
`define WCM_CTRL_DBI_EN  2
`define WCM_CTRL_ORG_LSB 3
`define WCM_CTRL_BST_LSB 5
`define WCM_CTRL_W       7
`define WCM_CTRL_RST     7'h08

// Status and mask bit positions
`define WCM_ST_ERR_LO    0
`define WCM_ST_ERR_HI    1
`define WCM_ST_BLOCKED   2
`define WCM_ST_DONE      3
`define WCM_ST_OTF_BAD   4
`define WCM_ST_W         5
`define WCM_MASK_RST     5'h00

// Frame layout
`define WCM_LAST_DATA    4'd7
`define WCM_CRC_XFER     4'd8
`define WCM_LAST_XFER    4'd9

// Checksum polynomial x^8+x^2+x+1 and start value
`define WCM_CRC_POLY     8'h07
`define WCM_CRC_INIT     8'h00

// Alert pulse length
`define WCM_CLK_MHZ      100
`define WCM_ALERT_NS     60
`define WCM_ALERT_CYC    ((`WCM_ALERT_NS * `WCM_CLK_MHZ + 999) / 1000)

`endif

// ==== inc/wcm_pkg.sv ====
// Types of the write checksum frame checker
// Assumes wcm_regs.svh for the numbers
package wcm_pkg;

  typedef enum logic [1:0] {WCM_ORG_X4, WCM_ORG_X8, WCM_ORG_X16} wcm_org_t;

  typedef enum logic [1:0] {
    WCM_BURST_LENGTH_EIGHT,
    WCM_BURST_CHOP_FOUR,
    WCM_ON_THE_FLY_BURST_SELECT
  } wcm_burst_t;

  typedef enum logic [1:0] {WCM_IDLE, WCM_CAPTURE, WCM_CHECK} wcm_fsm_t;

  // Control register, bit 0 at the bottom
  typedef struct packed {
    wcm_burst_t burst;
    wcm_org_t   org;
    logic       dbi_en;
    logic       dm_en;
    logic       crc_en;
  } wcm_ctrl_t;

  // Link pins, one transfer per rising strobe edge
  typedef struct packed {
    logic        strobe;
    logic        frame;
    logic        burst_chop_four;
    logic        burst_start_address_bit;
    logic        upper_mask_inversion_lane;
    logic        lower_mask_inversion_lane;
    logic [15:0] data_lane;
  } wcm_link_t;

  // Write toward the core
  typedef struct packed {
    logic         valid;
    logic [127:0] data;
    logic [15:0]  byte_en;
  } wcm_wr_t;

  typedef struct packed {
    wcm_link_t    sync1;
    wcm_link_t    sync2;
    logic         strobe_d;
    wcm_fsm_t     fsm;
    logic [3:0]   xfer;
    logic         chop;
    logic         start_hi;
    logic [143:0] cw;
    logic [15:0]  rx_crc;
    wcm_ctrl_t    ctrl;
    logic [4:0]   status;
    logic [4:0]   mask;
    logic [15:0]  last_rx;
    logic [15:0]  last_calc;
    logic [3:0]   alert_cnt;
    logic         alert_n;
    logic         irq;
    wcm_wr_t      wr;
    logic         aw_held;
    logic         w_held;
    logic [7:0]   awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } wcm_state_t;

endpackage : wcm_pkg

// ==== design/wcm_crc_tree.sv ====
// One 72-input checksum tree, x^8+x^2+x+1, zero start
// Assumes the caller fills unused inputs with ones
`timescale 1ns/1ns
`include "wcm_regs.svh"
module wcm_crc_tree (
  input  wire logic [71:0] code_word,
  output logic      [7:0]  crc
);
  import wcm_pkg::*;

  logic [7:0] acc;

  // Serial shift, bit 71 enters first
  always_comb begin
    acc = `WCM_CRC_INIT;
    for (int i = 71; i >= 0; i--) begin
      acc = {acc[6:0], 1'b0} ^ ((acc[7] ^ code_word[i]) ? `WCM_CRC_POLY : 8'h00);
    end
    crc = acc;
  end
endmodule : wcm_crc_tree

// ==== design/wcm_write_crc_checker.sv ====
// Write frame capture, checksum check, alert and AXI4-Lite registers
// Assumes link pins arrive unsynchronised; strobe much slower than aclk
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "wcm_regs.svh"
module wcm_write_crc_checker (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire wcm_pkg::wcm_link_t link_in,
  output logic                   alert_n,
  output logic                   irq,
  output wcm_pkg::wcm_wr_t       wr_out
);
  import wcm_pkg::*;

  wcm_state_t r;
  wcm_state_t n;
  logic       edge_s;
  logic       take;
  logic       chop_x;
  logic       hi_x;
  logic       mi_en;
  logic       is_x4;
  logic       is_x8;
  logic       is_x16;
  logic       on_the_fly_burst_select;
  logic       err_lo;
  logic       err_hi;
  logic [3:0] x;
  logic [2:0] pos;
  logic [3:0] last_x;
  logic [4:0] set_bits;
  logic [4:0] clr_bits;
  logic [7:0] calc_lo;
  logic [7:0] calc_hi;
  int         lanes;

  wcm_crc_tree u_crc_lo (
    .code_word (r.cw[71:0]),
    .crc       (calc_lo)
  );
  wcm_crc_tree u_crc_hi (
    .code_word (r.cw[143:72]),
    .crc       (calc_hi)
  );

  // Next state of everything
  always_comb begin
    n        = r;
    set_bits = '0;
    clr_bits = '0;
    err_lo   = 1'b0;
    err_hi   = 1'b0;
    pos      = 3'd0;

    // Two-stage synchronisers and strobe edge
    n.sync1    = link_in;
    n.sync2    = r.sync1;
    n.strobe_d = r.sync2.strobe;
    edge_s     = r.sync2.strobe & ~r.strobe_d;
    n.wr.valid = 1'b0;

    is_x4  = (r.ctrl.org == WCM_ORG_X4);
    is_x8  = (r.ctrl.org == WCM_ORG_X8);
    is_x16 = !is_x4 && !is_x8;
    mi_en  = r.ctrl.dm_en | r.ctrl.dbi_en;
    lanes  = is_x4 ? 4 : (is_x8 ? 8 : 16);
    last_x = r.ctrl.crc_en ? `WCM_LAST_XFER : `WCM_LAST_DATA;
    on_the_fly_burst_select    = (r.ctrl.burst == WCM_ON_THE_FLY_BURST_SELECT);

    // Burst kind of this transfer; fixed at first transfer
    // no on-the-fly with checksum
    if (r.fsm == WCM_IDLE) begin
      x      = 4'd0;
      chop_x = (r.ctrl.burst == WCM_BURST_CHOP_FOUR) ||
               (on_the_fly_burst_select && !r.ctrl.crc_en && r.sync2.burst_chop_four);
      hi_x   = chop_x & r.sync2.burst_start_address_bit;
    end else begin
      x      = r.xfer;
      chop_x = r.chop;
      hi_x   = r.start_hi;
    end
    take = edge_s && r.sync2.frame && (r.fsm != WCM_CHECK);

    // Frame dropped mid-burst aborts it
    if (r.fsm == WCM_CAPTURE && !r.sync2.frame) begin
      n.fsm = WCM_IDLE;
    end

    if (take) begin
      if (r.fsm == WCM_IDLE) begin
        n.cw     = '1;
        n.rx_crc = '1;
        n.chop   = chop_x;
        n.start_hi = hi_x;
        if (on_the_fly_burst_select && r.ctrl.crc_en) begin
          set_bits[`WCM_ST_OTF_BAD] = 1'b1;
        end
      end
      if (x <= `WCM_LAST_DATA) begin
        if (!(chop_x && x >= 4'd4)) begin
          pos = hi_x ? (x[2:0] + 3'd4) : x[2:0];
          for (int i = 0; i < 16; i++) begin
            if (i < lanes) begin
              n.cw[8 * i + (i >= 8 ? 8 : 0) + int'(pos)] = r.sync2.data_lane[i];
            end
          end
          if (mi_en && !is_x4) begin
            n.cw[64 + int'(pos)] = r.sync2.lower_mask_inversion_lane;
          end
          if (mi_en && is_x16) begin
            n.cw[136 + int'(pos)] = r.sync2.upper_mask_inversion_lane;
          end
        end
      end else if (x == `WCM_CRC_XFER) begin
        // checksum bit n on lane n
        for (int i = 0; i < 16; i++) begin
          if (i < lanes) begin
            n.rx_crc[i] = r.sync2.data_lane[i];
          end
        end
      end else if (is_x4) begin
        n.rx_crc[7:4] = r.sync2.data_lane[3:0];
      end
      if (x == last_x) begin
        n.fsm = WCM_CHECK;
      end else begin
        n.fsm  = WCM_CAPTURE;
        n.xfer = x + 4'd1;
      end
    end

    // Alert pulse countdown
    if (r.alert_cnt != 4'd0) begin
      n.alert_cnt = r.alert_cnt - 4'd1;
    end

    // One compare per burst, then commit or block
    if (r.fsm == WCM_CHECK) begin
      err_lo      = r.ctrl.crc_en && (r.rx_crc[7:0] != calc_lo);
      err_hi      = r.ctrl.crc_en && is_x16 && (r.rx_crc[15:8] != calc_hi);
      n.last_rx   = r.rx_crc;
      n.last_calc = {calc_hi, calc_lo};
      n.fsm       = WCM_IDLE;
      n.xfer      = 4'd0;
      set_bits[`WCM_ST_DONE] = 1'b1;
      if (err_lo || err_hi) begin
        n.alert_cnt = 4'(`WCM_ALERT_CYC);
        set_bits[`WCM_ST_ERR_LO] = err_lo;
        set_bits[`WCM_ST_ERR_HI] = err_hi;
      end
      if ((err_lo || err_hi) && r.ctrl.dm_en) begin
        set_bits[`WCM_ST_BLOCKED] = 1'b1;
      end else begin
        n.wr.valid = 1'b1;
        for (int t = 0; t < 8; t++) begin
          for (int i = 0; i < 8; i++) begin
            n.wr.data[8 * i + t] = r.cw[8 * i + t] ^ (r.ctrl.dbi_en & ~r.cw[64 + t]);
            n.wr.data[64 + 8 * i + t] = r.cw[72 + 8 * i + t] ^ (r.ctrl.dbi_en & ~r.cw[136 + t]);
          end
          n.wr.byte_en[t] = (!r.ctrl.dm_en || r.cw[64 + t]) &&
                            (!r.chop || (r.start_hi ? t >= 4 : t < 4));
          n.wr.byte_en[8 + t] = is_x16 && (!r.ctrl.dm_en || r.cw[136 + t]) &&
                                (!r.chop || (r.start_hi ? t >= 4 : t < 4));
        end
      end
    end
    n.alert_n = (n.alert_cnt == 4'd0);

    // AXI write address and data, either order
    if (awvalid && r.awready) begin
      n.aw_held = 1'b1;
      n.awaddr  = awaddr;
      n.awready = 1'b0;
    end
    if (wvalid && r.wready) begin
      n.w_held = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
      n.wready = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = 2'b00;
      if (r.awaddr == `WCM_CTRL_OFS) begin
        if (r.wstrb[0]) begin
          n.ctrl = wcm_ctrl_t'(r.wdata[`WCM_CTRL_W-1:0]);
        end
      end else if (r.awaddr == `WCM_STAT_OFS) begin
        clr_bits = r.wdata[`WCM_ST_W-1:0] & {`WCM_ST_W{r.wstrb[0]}};
      end else if (r.awaddr == `WCM_MASK_OFS) begin
        if (r.wstrb[0]) begin
          n.mask = r.wdata[`WCM_ST_W-1:0];
        end
      end else if (r.awaddr == `WCM_CRCV_OFS) begin
        n.bresp = 2'b00;
      end else begin
        n.bresp = 2'b10;
      end
    end
    if (r.bvalid && bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // AXI read, answer at the taking edge
    if (arvalid && r.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = 2'b00;
      if (araddr == `WCM_CTRL_OFS) begin
        n.rdata = {25'h0, r.ctrl};
      end else if (araddr == `WCM_STAT_OFS) begin
        n.rdata = {27'h0, r.status};
      end else if (araddr == `WCM_MASK_OFS) begin
        n.rdata = {27'h0, r.mask};
      end else if (araddr == `WCM_CRCV_OFS) begin
        n.rdata = {r.last_calc, r.last_rx};
      end else begin
        n.rdata = 32'h00000000;
        n.rresp = 2'b10;
      end
    end
    if (r.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // Sticky status, set beats clear; masked interrupt
    n.status = (r.status & ~clr_bits) | set_bits;
    n.irq    = |(n.status & n.mask);
  end

  // State register with freeze
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r           <= '0;
      r.ctrl      <= wcm_ctrl_t'(`WCM_CTRL_RST);
      r.mask      <= `WCM_MASK_RST;
      r.fsm       <= WCM_IDLE;
      r.alert_n   <= 1'b1;
      r.awready   <= 1'b1;
      r.wready    <= 1'b1;
      r.arready   <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign awready = r.awready;
  assign wready  = r.wready;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign arready = r.arready;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign alert_n = r.alert_n;
  assign irq     = r.irq;
  assign wr_out  = r.wr;
endmodule : wcm_write_crc_checker

// ==== tb/wcm_host_model.sv ====
// Host model: drives write bursts onto the link pins
// Assumes calls start right after a rising aclk edge
`timescale 1ns/1ns
module wcm_host_model (
  input  wire logic          aclk,
  output wcm_pkg::wcm_link_t link
);
  import wcm_pkg::*;

  // Link idle at time zero
  initial begin
    link = '0;
  end

  // One burst, strobe period 16 aclk, data held around each rise
  task automatic burst(input logic [17:0] xf [10], input logic ch, input logic sb);
    for (int k = 0; k < 10; k++) begin
      link.frame <= 1'b1;
      link.burst_chop_four <= ch;
      link.burst_start_address_bit <= sb;
      {link.upper_mask_inversion_lane, link.lower_mask_inversion_lane, link.data_lane} <= xf[k];
      repeat (4) @(posedge aclk);
      link.strobe <= 1'b1;
      repeat (8) @(posedge aclk);
      link.strobe <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    link.frame <= 1'b0;
    // Released lines show the inverse
    {link.upper_mask_inversion_lane, link.lower_mask_inversion_lane, link.data_lane} <= ~xf[9];
  endtask : burst
endmodule : wcm_host_model

// ==== tb/wcm_write_crc_checker_props.sv ====
// Port checker for the write checksum frame checker
// Assumes one clock domain and bind to the top module
`timescale 1ns/1ns
module wcm_wcc_props (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             awvalid,
  input wire logic             awready,
  input wire logic             wvalid,
  input wire logic             wready,
  input wire logic             bvalid,
  input wire logic             bready,
  input wire logic             arvalid,
  input wire logic             arready,
  input wire logic             rvalid,
  input wire logic             rready,
  input wire logic             alert_n,
  input wire wcm_pkg::wcm_wr_t wr_out
);
  import wcm_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Alert pulse then quiet
  sequence s_alert_low;
    !alert_n [*6];
  endsequence
  sequence s_quiet;
    alert_n [*8];
  endsequence

  a_alert_pulse_len: assert property ($fell(alert_n) |-> s_alert_low ##1 s_quiet)
    else $error("alert pulse length wrong");
  a_commit_once: assert property (wr_out.valid |=> !wr_out.valid [*8])
    else $error("commit repeated");
  a_wresp_next: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response late");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write ready while busy");
  a_bresp_done: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write response not closed");
  a_rresp_next: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  a_read_busy: assert property (rvalid |-> !arready)
    else $error("read ready while busy");
  a_rdata_done: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read response not closed");
endmodule : wcm_wcc_props

bind wcm_write_crc_checker wcm_wcc_props u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .alert_n(alert_n), .wr_out(wr_out)
);

// ==== tb/wcm_write_crc_checker_bench.sv ====
// Bench: table of bursts, then reset, interrupt and unmapped access
// Assumes wcm_host_model on the link and the bound port checker
`timescale 1ns/1ns
`include "wcm_regs.svh"
module wcm_write_crc_checker_bench;
  import wcm_pkg::*;
  typedef struct packed {
    logic [6:0] c;
    logic       sb;
    logic [1:0] bad;
    logic [7:0] m;
    logic [4:0] st;
  } wcm_row_t;
  logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, alert_n, irq;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, m32, crcv;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  wcm_link_t    link;
  wcm_wr_t      wr_out;
  logic [127:0] got, p, e, mw;
  logic [17:0]  xf [10];
  logic [15:0]  c, gbe, ebe;
  int           num_errors, checked, n_al, n_wr, a0, w0;
  wcm_row_t     rows [9] = '{'{7'h09, 0, 0, 8'hff, 5'h08}, '{7'h09, 0, 1, 8'hff, 5'h09},
    '{7'h0b, 0, 1, 8'hff, 5'h0d}, '{7'h15, 0, 0, 8'hf0, 5'h08}, '{7'h15, 0, 2, 8'h3c, 5'h0a},
    '{7'h21, 1, 0, 8'hff, 5'h08}, '{7'h2b, 0, 0, 8'ha5, 5'h08}, '{7'h2b, 1, 1, 8'h5a, 5'h0d},
    '{7'h49, 0, 0, 8'hff, 5'h18}};

  wcm_host_model host (.aclk(aclk), .link(link));
  wcm_write_crc_checker uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link_in(link), .alert_n(alert_n), .irq(irq), .wr_out(wr_out));

  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Count alert cycles and commits
  always @(posedge aclk) begin
    if (alert_n === 1'b0) n_al <= n_al + 1;
    if (wr_out.valid === 1'b1) begin
      n_wr <= n_wr + 1;
      got <= wr_out.data;
      gbe <= wr_out.byte_en;
    end
  end

  task automatic chk(input logic [127:0] s, input logic [127:0] x);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ok;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
    repeat (50) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk(bresp, er);
        ok = 1'b1;
        break;
      end
    end
    // No response within the limit counts as a mismatch
    if (!ok) chk(1'b0, 1'b1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, mk, input logic [1:0] er);
    bit ok;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    repeat (50) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        chk(rdata & mk, x & mk);
        chk(rresp, er);
        ok = 1'b1;
        break;
      end
    end
    // No read data within the limit counts as a mismatch
    if (!ok) chk(1'b0, 1'b1);
  endtask : rdc

  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 71; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h07 : 8'h00);
    return r;
  endfunction : crc8

  // Frame, code word and expected data for one row
  task automatic build(input wcm_row_t r);
    logic [143:0] cw;
    logic [15:0]  cs;
    logic         ch, u, v;
    int           q;
    cw = '1;
    ch = r.c[6:5] == 2'd1;
    e = p;
    mw = r.c[4] ? '1 : r.c[3] ? 128'(64'hffffffffffffffff) : 128'(32'hffffffff);
    foreach (xf[k]) xf[k] = '1;
    for (int n = 0; n < 18; n++) begin
      for (int t = 0; t < 8; t++) begin
        q = n < 8 ? 8 * n + t : n < 16 ? 8 * n + 8 + t : n == 16 ? 64 + t : 136 + t;
        u = (n < 4 || r.c[4] || (r.c[3] && (n < 8 || n == 16))) && (n < 16 || r.c[2:1] != 0);
        u = u && (!ch || t[2] == r.sb);
        v = n < 16 ? p[8 * n + t] : r.m[t];
        if (u) begin
          cw[q] = v;
          xf[ch ? t - 4 * r.sb : t][n] = v;
        end
        if (n < 16) e[8 * n + t] = v ^ (r.c[2] & ~r.m[t]);
        // Chopped half is never sent, so leave it out of the compare
        if (n < 16 && ch && t[2] != r.sb) mw[8 * n + t] = 1'b0;
      end
    end
    c = {crc8(cw[143:72]), crc8(cw[71:0])};
    cs = c ^ {7'h0, r.bad[1], 7'h0, r.bad[0]};
    for (int n = 0; n < 16; n++) begin
      if (n < 4 || r.c[4] || (r.c[3] && n < 8)) xf[8][n] = cs[n];
      if (r.c[4:3] == 2'd0 && n < 4) xf[9][n] = cs[n + 4];
    end
    m32 = r.c[4] ? '1 : 32'h00ff00ff;
    crcv = {c, cs};
    // Byte enables: mask lane and the chopped half
    for (int t = 0; t < 8; t++) begin
      ebe[t] = (!r.c[1] || r.c[4:3] == 2'd0 || r.m[t]) && (!ch || t[2] == r.sb);
      ebe[8 + t] = r.c[4] & ebe[t];
    end
  endtask : build

  task give_verdict();
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    #500000;
    num_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk({alert_n, irq}, 2'b10);
    rdc(`WCM_CTRL_OFS, 32'h08, '1, 2'b00);
    rdc(`WCM_MASK_OFS, 32'h00, '1, 2'b00);
    rdc(`WCM_STAT_OFS, 32'h00, '1, 2'b00);
    foreach (rows[i]) begin
      wr(`WCM_CTRL_OFS, 32'(rows[i].c), 2'b00);
      p = {8{16'h1234 + 16'(i) * 16'h0f1d}} ^ {4{32'h9e3779b9}};
      build(rows[i]);
      a0 = n_al;
      w0 = n_wr;
      host.burst(xf, rows[i].c[6] | (rows[i].c[6:5] == 2'd1), rows[i].sb);
      repeat (4) @(posedge aclk);
      chk(n_al - a0, rows[i].bad != 0 ? `WCM_ALERT_CYC : 0);
      chk(n_wr - w0, (rows[i].bad == 0 || !rows[i].c[1]) ? 1 : 0);
      if (rows[i].bad == 0 || !rows[i].c[1]) begin
        chk(got & mw, e & mw);
        chk(gbe, ebe);
      end
      rdc(`WCM_STAT_OFS, 32'(rows[i].st), '1, 2'b00);
      rdc(`WCM_CRCV_OFS, crcv, m32, 2'b00);
      chk(irq, 1'b0);
      wr(`WCM_STAT_OFS, 32'h1f, 2'b00);
    end
    // Mid-run reset brings back the reset values
    wr(`WCM_MASK_OFS, 32'h1f, 2'b00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({alert_n, irq, wr_out.valid}, 3'b100);
    rdc(`WCM_CTRL_OFS, 32'h08, '1, 2'b00);
    rdc(`WCM_MASK_OFS, 32'h00, '1, 2'b00);
    // Unmasked error raises the interrupt, W1C drops it
    wr(`WCM_MASK_OFS, 32'h1f, 2'b00);
    wr(`WCM_CTRL_OFS, 32'h09, 2'b00);
    build(rows[1]);
    host.burst(xf, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    chk(irq, 1'b1);
    wr(`WCM_STAT_OFS, 32'h1f, 2'b00);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    // Unmapped address
    wr(8'h10, 32'h0, 2'b10);
    rdc(8'h10, 32'h0, '1, 2'b10);
    give_verdict();
  end
endmodule : wcm_write_crc_checker_bench
